// ===== hdl/display_extension_control.sv
// indexed display extension registers behind an axi4-lite slave
`include "dx_consts.svh"
module display_extension_control (
    input  wire logic              aclk,          // 200 mhz clock
    input  wire logic              aresetn,       // sync reset, low
    input  wire logic [11:0]       awaddr,        // write address
    input  wire logic [2:0]        awprot,        // unused
    input  wire logic              awvalid,       // write addr valid
    output logic                   awready,       // write addr ready
    input  wire logic [31:0]       wdata,         // write data
    input  wire logic [3:0]        wstrb,         // byte enables
    input  wire logic              wvalid,        // write data valid
    output logic                   wready,        // write data ready
    output logic [1:0]             bresp,         // write response
    output logic                   bvalid,        // response valid
    input  wire logic              bready,        // response ready
    input  wire logic [11:0]       araddr,        // read address
    input  wire logic [2:0]        arprot,        // unused
    input  wire logic              arvalid,       // read addr valid
    output logic                   arready,       // read addr ready
    output logic [31:0]            rdata,         // read data
    output logic [1:0]             rresp,         // read response
    output logic                   rvalid,        // read data valid
    input  wire logic              rready,        // read data ready
    input  wire logic              hsync_in,      // raw horiz sync
    input  wire logic              vsync_in,      // raw vert sync
    input  wire logic              forty_col_in,  // 40 column mode
    input  wire logic              attr_intensity_in, // attr bit
    input  wire logic              timing_wr_in,  // timing reg write
    input  wire logic              timing_wr_legacy, // legacy target
    output logic                   timing_wr_pass_q, // write allowed
    output logic                   horizontal_sync_output, // hsync
    output logic                   vertical_sync_output,   // vsync
    output dx_pkg::display_ctl_t   ctl_q,         // steering bits
    output logic                   font_normal_q, // 1 normal, 0 thin
    output logic                   intensify_q,   // crt intensified
    output logic [3:0]             frame_shade_q  // frame grey
);
    import dx_pkg::*;

    // ------------------------------------------------------------
    // register table
    // ------------------------------------------------------------
    localparam int NREG      = 13;
    localparam int R_MISC1   = 0;
    localparam int R_WRCTL   = 1;
    localparam int R_TIMING  = 2;
    localparam int R_BANDW   = 3;
    localparam int R_CARET_W = 4;
    localparam int R_CARET_H = 5;
    localparam int R_POINTER = 6;
    localparam int R_ADAPTER = 7;
    localparam int R_USER0   = 8;
    localparam int R_USER1   = 9;
    localparam int R_USER2   = 10;
    localparam int R_PANEL2  = 11;
    localparam int R_FRAME   = 12;

    localparam logic [7:0] IDX_TAB [NREG] = '{
        `IDX_MISC1, `IDX_WRCTL, `IDX_TIMING, `IDX_BANDW,
        `IDX_CARET_W, `IDX_CARET_H, `IDX_POINTER, `IDX_ADAPTER,
        `IDX_USER0, `IDX_USER1, `IDX_USER2, `IDX_PANEL2,
        `IDX_FRAME
    };

    // caret sizes come up at one so the pointer can reverse the crt
    localparam logic [7:0] RST_TAB [NREG] = '{
        `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO,
        `RST_CARET, `RST_CARET, `RST_ZERO, `RST_ZERO,
        `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO,
        `RST_ZERO
    };

    logic [7:0]      regs_q [NREG];
    logic [7:0]      wr_val [NREG];
    logic [NREG-1:0] w_hit;
    logic [NREG-1:0] r_hit;

    // ------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------
    logic        aw_full_q;
    logic        w_full_q;
    logic [11:0] wa_q;
    logic [7:0]  wd_q;
    logic        wl_q;
    logic        aw_take;
    logic        w_take;
    logic        wr_fire;
    logic        aw_full_d;
    logic        w_full_d;
    logic        bvalid_d;
    logic        w_mapped;

    assign aw_take   = awvalid & awready;
    assign w_take    = wvalid & wready;
    // address and data may arrive in either order
    assign wr_fire   = aw_full_q & w_full_q & ~bvalid;
    assign aw_full_d = (aw_full_q | aw_take) & ~wr_fire;
    assign w_full_d  = (w_full_q | w_take) & ~wr_fire;
    assign bvalid_d  = wr_fire | (bvalid & ~bready);
    assign w_mapped  = |w_hit;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            wa_q      <= 12'h000;
            wd_q      <= 8'h00;
            wl_q      <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= `RESP_OKAY;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            awready   <= ~aw_full_d & ~bvalid_d;
            wready    <= ~w_full_d & ~bvalid_d;
            bvalid    <= bvalid_d;
            if (aw_take) begin
                wa_q <= awaddr;
            end
            if (w_take) begin
                wd_q <= wdata[7:0];
                wl_q <= wstrb[0];
            end
            if (wr_fire) begin
                bresp <= w_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // decode and storage
    // ------------------------------------------------------------
    logic [2:0] cur_state;

    assign cur_state = regs_q[R_ADAPTER][2:0];

    for (genvar g = 0; g < NREG; g++) begin : g_reg
        assign w_hit[g] = (wa_q[11:10] == 2'h0)
                        && (wa_q[9:2] == IDX_TAB[g]);
        assign r_hit[g] = (araddr[11:10] == 2'h0)
                        && (araddr[9:2] == IDX_TAB[g]);
        if (g == R_ADAPTER) begin : g_adp
            // old current state slides into the history field
            assign wr_val[g] = {1'b0, cur_state,
                                1'b0, wd_q[2:0]};
        end else if (g == R_FRAME) begin : g_frm
            assign wr_val[g] = {4'h0, wd_q[3:0]};
        end else begin : g_pln
            assign wr_val[g] = wd_q;
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                regs_q[g] <= RST_TAB[g];
            end else if (wr_fire && wl_q && w_hit[g]) begin
                regs_q[g] <= wr_val[g];
            end
        end
    end

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    logic       ar_take;
    logic [7:0] rd_mux;

    assign ar_take = arvalid & arready;

    always_comb begin
        rd_mux = 8'h00;
        for (int i = 0; i < NREG; i++) begin
            rd_mux = rd_mux | (r_hit[i] ? regs_q[i] : 8'h00);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `RESP_OKAY;
        end else if (ar_take) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, rd_mux};
            rresp   <= (|r_hit) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // display steering
    // ------------------------------------------------------------
    logic         colour_mono_graphics_emulation;
    logic         bw_fast;
    logic         crt_op;
    logic         fonts_on;
    logic         block_now;
    interleave_t  il_d;
    display_ctl_t ctl_d;

    // polarity tweaks only apply in colour or mono graphics emulation
    assign colour_mono_graphics_emulation = (cur_state == ST_CGA)
               || (cur_state == ST_MGA);
    // bandwidth register is dead while misc bit 4 is set
    assign bw_fast = ~regs_q[R_MISC1][`MC1_BW_OFF]
                   & regs_q[R_BANDW][`BW_FAST];
    assign il_d = forty_col_in ? IL_3_2 :
                  bw_fast      ? IL_1_1 : IL_1_4;
    assign crt_op   = regs_q[R_USER0][`U0_CRT_OP];
    // font option bits are active low
    assign fonts_on = crt_op ? ~regs_q[R_USER2][`U2_FONT_CRT]
                             : ~regs_q[R_USER0][`U0_FONT_LCD];
    assign block_now = timing_wr_legacy
                     ? regs_q[R_WRCTL][`WRC_LEGACY]
                     : regs_q[R_WRCTL][`WRC_STD];

    assign ctl_d.scan_double     = regs_q[R_TIMING][`TC_SCAN_DBL];
    assign ctl_d.legacy_wr_block = regs_q[R_WRCTL][`WRC_LEGACY];
    assign ctl_d.std_wr_block    = regs_q[R_WRCTL][`WRC_STD];
    assign ctl_d.panel_reverse   =
        regs_q[R_PANEL2][`PC2_REVERSE];
    // reverse only works while the caret is one by one
    assign ctl_d.crt_reverse = (regs_q[R_CARET_W] == 8'h01)
                            && (regs_q[R_CARET_H] == 8'h01)
                            && regs_q[R_POINTER][`PTR_REVERSE];
    assign ctl_d.interleave = il_d;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_q                  <= '0;
            horizontal_sync_output <= 1'b0;
            vertical_sync_output   <= 1'b0;
            timing_wr_pass_q       <= 1'b0;
            font_normal_q          <= 1'b1;
            intensify_q            <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            horizontal_sync_output <= hsync_in
                ^ (colour_mono_graphics_emulation & regs_q[R_TIMING][`TC_HPOL]);
            vertical_sync_output <= vsync_in
                ^ (colour_mono_graphics_emulation & regs_q[R_TIMING][`TC_VPOL]);
            // a protected write is simply dropped
            timing_wr_pass_q <= timing_wr_in & ~block_now;
            font_normal_q <= fonts_on ? attr_intensity_in
                                      : 1'b1;
            intensify_q <= crt_op & attr_intensity_in;
        end
    end

    frame_shade u_frame (
        .aclk    (aclk),
        .aresetn (aresetn),
        .grey    (regs_q[R_FRAME][3:0]),
        .reverse (regs_q[R_PANEL2][`PC2_REVERSE]),
        .shade_q (frame_shade_q)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_scan_double_set: assert property (
        wr_fire && wl_q && w_hit[R_TIMING]
        |-> ##2 ctl_q.scan_double == $past(wd_q[4], 2))
        else $error("scan doubling did not follow timing write");

    a_hsync_invert: assert property (
        colour_mono_graphics_emulation && regs_q[R_TIMING][`TC_HPOL]
        |=> horizontal_sync_output == !$past(hsync_in))
        else $error("hsync not inverted in graphics emulation");

    a_vsync_plain: assert property (
        !colour_mono_graphics_emulation |=> vertical_sync_output == $past(vsync_in))
        else $error("vsync altered outside graphics emulation");

    a_state_history: assert property (
        wr_fire && wl_q && w_hit[R_ADAPTER]
        |=> regs_q[R_ADAPTER][6:4] == $past(cur_state)
            && regs_q[R_ADAPTER][2:0] == $past(wd_q[2:0]))
        else $error("adapter state history lost");

    a_bandwidth_ignored: assert property (
        !forty_col_in && regs_q[R_MISC1][`MC1_BW_OFF]
        |=> ctl_q.interleave == IL_1_4)
        else $error("bandwidth register used while disabled");

    a_forty_fixed: assert property (
        forty_col_in |=> ctl_q.interleave == IL_3_2)
        else $error("forty column interleave not 3:2");

    a_fast_ratio: assert property (
        !forty_col_in && !regs_q[R_MISC1][`MC1_BW_OFF]
        && regs_q[R_BANDW][`BW_FAST]
        |=> ctl_q.interleave == IL_1_1)
        else $error("fast mode interleave not 1:1");

    a_legacy_blocked: assert property (
        timing_wr_in && timing_wr_legacy
        && regs_q[R_WRCTL][`WRC_LEGACY] |=> !timing_wr_pass_q)
        else $error("legacy timing write passed while protected");

    a_std_blocked: assert property (
        timing_wr_in && !timing_wr_legacy
        && regs_q[R_WRCTL][`WRC_STD] |=> !timing_wr_pass_q)
        else $error("standard timing write passed while protected");

    a_protect_now: assert property (
        wr_fire && wl_q && w_hit[R_WRCTL] && wd_q[`WRC_STD]
        ##1 timing_wr_in && !timing_wr_legacy |=> !timing_wr_pass_q)
        else $error("protection late after write control update");

    a_panel_reverse: assert property (
        wr_fire && wl_q && w_hit[R_PANEL2]
        |-> ##2 ctl_q.panel_reverse == $past(wd_q[6], 2))
        else $error("panel reverse did not follow write");

    a_crt_reverse: assert property (
        regs_q[R_CARET_W] != 8'h01 |=> !ctl_q.crt_reverse)
        else $error("crt reverse without one by one caret");

    a_frame_range: assert property (
        regs_q[R_FRAME][7:4] == 4'h0)
        else $error("frame grey above 15");

    a_frame_reversed: assert property (
        regs_q[R_PANEL2][`PC2_REVERSE]
        |=> frame_shade_q == ~$past(regs_q[R_FRAME][3:0]))
        else $error("frame shade not reversed with text");

    a_thin_default: assert property (
        fonts_on && !attr_intensity_in |=> !font_normal_q)
        else $error("thin font not used by default");

    a_crt_intensify: assert property (
        crt_op && attr_intensity_in |=> intensify_q)
        else $error("bold character not intensified on crt");

    a_read_answer: assert property (
        ar_take |=> rvalid && rdata[31:8] == 24'h00_0000)
        else $error("read not answered next cycle");

    c_write_done: cover property (
        wr_fire ##1 bvalid && bready);
    c_read_done: cover property (
        ar_take ##1 rvalid && rready);
    c_fast_mode: cover property (
        ctl_q.interleave == IL_1_1);
    c_blocked_write: cover property (
        timing_wr_in && block_now);
endmodule

// ===== hdl/dx_consts.svh
// offsets, field positions and reset values of the display extension bank
// What this block does
// - timing control bit 4 set doubles scan lines for legacy emulation.
// - timing bits 6 and 7 invert hsync and vsync in graphics emulation.
// - adapter state register keeps current state and the previous one.
// - bandwidth control counts only while misc control one bit 4 is zero.
// - forty column modes always use a fixed 3:2 interleave.
// - other modes use 1:4 when safe and 1:1 when fast.
// - write control bit 4 blocks writes to legacy timing registers.
// - write control bit 0 blocks standard timing and clock select writes.
// - protected timing writes are dropped as soon as the bits change.
// - panel control two bit 6 turns panel text reverse video on.
// - one by one caret lets pointer attributes reverse the crt.
// - frame grey level sets shade 0 to 15 outside the image.
// - the frame shade reverses together with panel reverse video.
// - with font intensity, thin font is default, intensity picks normal.
// - on crt, intensity characters are also shown intensified.
`ifndef DX_CONSTS_SVH
`define DX_CONSTS_SVH
// register indices; byte address is four times the index
`define IDX_MISC1     8'h80
`define IDX_WRCTL     8'h84
`define IDX_TIMING    8'h85
`define IDX_BANDW     8'h86
`define IDX_CARET_W   8'h96
`define IDX_CARET_H   8'h97
`define IDX_POINTER   8'ha5
`define IDX_ADAPTER   8'haf
`define IDX_USER0     8'hb0
`define IDX_USER1     8'hb1
`define IDX_USER2     8'hb2
`define IDX_PANEL2    8'hd5
`define IDX_FRAME     8'hda
// field positions
`define TC_SCAN_DBL   4
`define TC_HPOL       6
`define TC_VPOL       7
`define MC1_BW_OFF    4
`define BW_FAST       0
`define WRC_LEGACY    4
`define WRC_STD       0
`define PC2_REVERSE   6
`define PTR_REVERSE   0
`define U0_CRT_OP     0
`define U0_FONT_LCD   5
`define U2_FONT_CRT   5
// reset values
`define RST_ZERO      8'h00
`define RST_CARET     8'h01
// bus answers
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10
`endif

// ===== hdl/dx_pkg.sv
// types shared by the display extension bank
package dx_pkg;
    typedef enum logic [1:0] {
        IL_1_4 = 2'h0,
        IL_1_1 = 2'h1,
        IL_3_2 = 2'h3
    } interleave_t;

    typedef enum logic [2:0] {
        ST_RSVD = 3'h0,
        ST_CGA  = 3'h1,
        ST_MGA  = 3'h2,
        ST_EGA  = 3'h3,
        ST_VGA  = 3'h4
    } emul_state_t;

    typedef struct packed {
        logic        scan_double;
        logic        legacy_wr_block;
        logic        std_wr_block;
        logic        panel_reverse;
        logic        crt_reverse;
        interleave_t interleave;
    } display_ctl_t;
endpackage

// ===== hdl/frame_shade.sv
// frame grey shade, reversed together with panel text reverse video
module frame_shade (
    input  wire logic       aclk,        // system clock
    input  wire logic       aresetn,     // sync reset, active low
    input  wire logic [3:0] grey,        // programmed shade 0..15
    input  wire logic       reverse,     // panel reverse video on
    output logic      [3:0] shade_q      // shade sent to the panel
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shade_q <= 4'h0;
        end else begin
            shade_q <= reverse ? ~grey : grey;
        end
    end
endmodule

// ===== testbench/display_extension_control_tb.sv
// self-checking bench for the display extension register bank
`include "dx_consts.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
    mismatches++; $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
    end end
module display_extension_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // signals and design
    // ----------------------------------------------------------------
    logic                 aclk, aresetn;
    logic [11:0]          awaddr, araddr;
    logic [2:0]           awprot, arprot;
    logic                 awvalid, awready, wvalid, wready, bvalid, bready;
    logic                 arvalid, arready, rvalid, rready;
    logic [31:0]          wdata, rdata;
    logic [3:0]           wstrb, shade;
    logic [1:0]           bresp, rresp;
    logic                 hsync_in, vsync_in, forty_col, attr_in;
    logic                 twr, twr_leg, twr_pass, hs_out, vs_out;
    logic                 font_normal, intensify;
    dx_pkg::display_ctl_t ctl;
    int                   mismatches, checks_done;
    logic [31:0]          d;
    logic [1:0]           r;
    logic [7:0]           idx_tab [13] = '{8'h80, 8'h84, 8'h85, 8'h86,
        8'h96, 8'h97, 8'ha5, 8'haf, 8'hb0, 8'hb1, 8'hb2, 8'hd5, 8'hda};

    display_extension_control u_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(arprot),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .hsync_in(hsync_in),
        .vsync_in(vsync_in), .forty_col_in(forty_col),
        .attr_intensity_in(attr_in), .timing_wr_in(twr),
        .timing_wr_legacy(twr_leg), .timing_wr_pass_q(twr_pass),
        .horizontal_sync_output(hs_out), .vertical_sync_output(vs_out),
        .ctl_q(ctl), .font_normal_q(font_normal), .intensify_q(intensify),
        .frame_shade_q(shade)
    );

    always #2.5 aclk = ~aclk;

    // ----------------------------------------------------------------
    // bus tasks; each is entered just after a rising edge
    // ----------------------------------------------------------------
    task automatic axi_wr(input logic [7:0] idx, input logic [7:0] v,
                          input logic [3:0] s, output logic [1:0] resp);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= {24'h000000, v};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        resp = bresp;
    endtask

    task automatic axi_rd(input logic [7:0] idx, output logic [31:0] v,
                          output logic [1:0] resp);
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        v = rdata;
        resp = rresp;
    endtask

    // write, expect okay, then let the steering outputs follow
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [1:0] resp;
        axi_wr(idx, v, 4'h1, resp);
        `CHK(resp, `RESP_OKAY)
        repeat (3) @(posedge aclk);
    endtask

    task automatic settle();
        repeat (3) @(posedge aclk);
    endtask

    task automatic end_sim();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // watchdog: the whole sequence needs well under 2000 cycles
    // ----------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        {aclk, aresetn, awaddr, araddr, awprot, arprot} = '0;
        {awvalid, wvalid, arvalid, wdata, wstrb} = '0;
        // answers are always accepted, so back to back calls never
        // lower and raise a ready in the same step
        {bready, rready} = 2'b11;
        {hsync_in, vsync_in, forty_col, attr_in, twr, twr_leg} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (idx_tab[i]) begin
            axi_rd(idx_tab[i], d, r);
            `CHK(r, `RESP_OKAY)
            `CHK(d[7:0], {7'h00, idx_tab[i][7:1] == 7'h4b})
        end
        // state field 4 in bits 7:5, the highest code software may use
        wr(`IDX_USER1, 8'h83);
        axi_rd(`IDX_USER1, d, r);
        `CHK(d, 32'h00000083)
        // adapter record keeps the state before the last one
        wr(`IDX_ADAPTER, 8'h03);
        wr(`IDX_ADAPTER, 8'h01);
        axi_rd(`IDX_ADAPTER, d, r);
        `CHK(d, 32'h00000031)
        wr(`IDX_TIMING, 8'hd0);
        `CHK(ctl.scan_double, 1'b1)
        hsync_in <= 1'b1;
        settle();
        `CHK({hs_out, vs_out}, 2'b01)
        wr(`IDX_ADAPTER, 8'h04);
        `CHK({hs_out, vs_out}, 2'b10)
        axi_rd(`IDX_ADAPTER, d, r);
        `CHK(d, 32'h00000014)
        // interleave selection
        wr(`IDX_BANDW, 8'h01);
        `CHK(ctl.interleave, dx_pkg::IL_1_1)
        wr(`IDX_MISC1, 8'h10);
        `CHK(ctl.interleave, dx_pkg::IL_1_4)
        wr(`IDX_MISC1, 8'h00);
        forty_col <= 1'b1;
        settle();
        `CHK(ctl.interleave, dx_pkg::IL_3_2)
        forty_col <= 1'b0;
        wr(`IDX_BANDW, 8'h00);
        `CHK(ctl.interleave, dx_pkg::IL_1_4)
        // protection of timing writes, every bit pattern and target
        for (int i = 0; i < 8; i++) begin
            wr(`IDX_WRCTL, {3'b000, i[1], 3'b000, i[0]});
            `CHK({ctl.legacy_wr_block, ctl.std_wr_block}, i[1:0])
            twr <= 1'b1;
            twr_leg <= i[2];
            @(posedge aclk);
            twr <= 1'b0;
            @(posedge aclk);
            `CHK(twr_pass, i[2] ? ~i[1] : ~i[0])
        end
        wr(`IDX_WRCTL, 8'h00);
        // requests held across a write control update: blocked at once
        twr <= 1'b1;
        twr_leg <= 1'b0;
        settle();
        `CHK(twr_pass, 1'b1)
        axi_wr(`IDX_WRCTL, 8'h01, 4'h1, r);
        @(posedge aclk);
        `CHK(twr_pass, 1'b0)
        twr <= 1'b0;
        wr(`IDX_WRCTL, 8'h00);
        // frame shade, panel reverse, empty strobe
        wr(`IDX_FRAME, 8'h05);
        `CHK(shade, 4'h5)
        axi_wr(`IDX_FRAME, 8'h0f, 4'h0, r);
        `CHK(r, `RESP_OKAY)
        axi_rd(`IDX_FRAME, d, r);
        `CHK(d, 32'h00000005)
        wr(`IDX_PANEL2, 8'h40);
        `CHK(ctl.panel_reverse, 1'b1)
        `CHK(shade, 4'ha)
        wr(`IDX_PANEL2, 8'h00);
        `CHK(shade, 4'h5)
        // caret geometry gates crt reverse video
        wr(`IDX_POINTER, 8'h01);
        `CHK(ctl.crt_reverse, 1'b1)
        wr(`IDX_CARET_W, 8'h02);
        `CHK(ctl.crt_reverse, 1'b0)
        wr(`IDX_CARET_W, 8'h01);
        `CHK(ctl.crt_reverse, 1'b1)
        // intensity with fonts, panel then crt
        attr_in <= 1'b1;
        settle();
        `CHK(font_normal, 1'b1)
        attr_in <= 1'b0;
        settle();
        `CHK(font_normal, 1'b0)
        wr(`IDX_USER0, 8'h20);
        `CHK(font_normal, 1'b1)
        wr(`IDX_USER0, 8'h01);
        attr_in <= 1'b1;
        settle();
        `CHK({font_normal, intensify}, 2'b11)
        attr_in <= 1'b0;
        settle();
        `CHK({font_normal, intensify}, 2'b00)
        // unmapped index refuses both directions
        axi_wr(8'h81, 8'h5a, 4'h1, r);
        `CHK(r, `RESP_SLVERR)
        axi_rd(8'h81, d, r);
        `CHK({d, r}, {32'h00000000, `RESP_SLVERR})
        end_sim();
    end
endmodule
